// File: core/grp_target.sv
// Purpose: two-wire target logic for a switchable reference-voltage generator
// Assumes: bus lines and straps are asynchronous pins; refresh clock pin is a clock
// Notes: channel codes are moved into the refresh domain by a toggle handshake
//
// Contract
// [R1] first byte is address; upper six 111010
// [R2] address low bit from select pin
// [R3] accept only after own address recognised
// [R4] direction bit: 0 write, 1 read
// [R5] reads return previously programmed codes
// [R6] write bank select picks written bank
// [R7] read bank select picks read-back bank
// [R8] internal source: drive refresh pin with oscillator
// [R9] external source: refresh pin is input
// [R10] lag select adds 3.5 us lag
// [R11] upper four control bits ignored
// [R12] code bytes unsigned, msb first
// [R13] refresh on falling, open on rising
// [R14] internal oscillator near 21 kHz
// [R15] refresh pin released after power-on
// [R16] channels updated in a continuous cycle
// [R17] system times loads away from rising edges
// [R18] write: control then fourteen codes, all acknowledged
// [R19] read: fourteen codes, controller ends with nack
// [R20] standard frames only while frame pin high
// [R21] bank pin picks set driving outputs
// [R22] settings retained; bus lines synchronised
`timescale 1ns/1ps
`default_nettype none
`include "grp_params.svh"

module grp_target (
  // clocks and reset
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  // serial bus, data is open drain
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_OUT,
  // straps and select pins
  input wire logic ADDRESS_SELECT_PIN_IN,
  input wire logic FRAME_MODE_PIN_IN,
  input wire logic BANK_SELECT_PIN_IN,
  // refresh clock pin, input side clocks the refresh domain
  input wire logic REFRESH_CLOCK_PIN_IN,
  output logic REFRESH_CLOCK_PIN_OUT,
  output logic REFRESH_CLOCK_PIN_OE_OUT,
  // refreshed channel codes and switch control
  output grp_pkg::grp_code_set_s CHANNEL_CODES_OUT,
  output logic SWITCH_OPEN_OUT
);

  // oscillator half period in core cycles, used by the checks below
  localparam int OSC_HALF = `GRP_OSC_HALF_CYC;

  // full state of each domain
  grp_pkg::grp_core_s q, d;
  grp_pkg::grp_refresh_s rq, rd;

  // bus events, seen only on synchronised copies
  logic scl_rise, scl_fall, start_ev, stop_ev, sda_s, scl_s;
  assign scl_s = q.scl_sy[1];
  assign sda_s = q.sda_sy[1];
  assign scl_rise = scl_s & ~q.scl_p;
  assign scl_fall = ~scl_s & q.scl_p;
  assign start_ev = scl_s & q.scl_p & q.sda_p & ~sda_s;
  assign stop_ev = scl_s & q.scl_p & ~q.sda_p & sda_s;

  // own address with the low bit taken from the select pin
  function automatic logic addr_hit(input logic [7:0] b, input logic a0);
    addr_hit = (b[7:1] == {`GRP_ADDR_HIGH6, a0}); // see [R1] see [R2]
  endfunction

  // code for channel index, idle code past the last channel
  function automatic logic [7:0] pick_code(input grp_pkg::grp_code_set_s s,
                                           input logic [4:0] idx);
    if (idx < 5'(`GRP_NUM_CH)) begin
      pick_code = s.code[idx[3:0]];
    end else begin
      pick_code = `GRP_IDLE_CODE;
    end
  endfunction

  // next state of the core domain
  always_comb begin
    logic [4:0] widx;
    logic [7:0] txb;
    widx = q.bytecnt - `GRP_FIRST_CODE_WR;
    txb = 8'h00;
    d = q;
    // two flip-flops per pin before any logic looks at it, see [R22]
    d.scl_sy = {q.scl_sy[0], SCL_IN};
    d.sda_sy = {q.sda_sy[0], SDA_IN};
    d.a0_sy = {q.a0_sy[0], ADDRESS_SELECT_PIN_IN};
    d.mode_sy = {q.mode_sy[0], FRAME_MODE_PIN_IN};
    d.bsel_sy = {q.bsel_sy[0], BANK_SELECT_PIN_IN};
    d.rclk_sy = {q.rclk_sy[0], REFRESH_CLOCK_PIN_IN};
    d.ack_sy = {q.ack_sy[0], rq.seen};
    d.scl_p = scl_s;
    d.sda_p = sda_s;
    // open-drain data: the driven level is always low
    d.sda_lvl = 1'b0;

    unique case (q.st)
      // waiting for a start condition, see [R3]
      grp_pkg::ST_IDLE: begin
        d.sda_oe = 1'b0;
      end
      // shifting a byte in, msb first, see [R12]
      grp_pkg::ST_RX: begin
        if (scl_rise) begin
          d.shreg = {q.shreg[6:0], sda_s};
          d.bitcnt = q.bitcnt + 3'h1;
          d.last_bit = (q.bitcnt == 3'h7);
        end else if (scl_fall && q.last_bit) begin
          d.last_bit = 1'b0;
          d.bitcnt = 3'h0;
          d.bytecnt = (q.bytecnt == 5'h1f) ? q.bytecnt : q.bytecnt + 5'h01;
          if (q.bytecnt == 5'h00) begin
            // only standard frames to our own address are taken
            if (addr_hit(q.shreg, q.a0_sy[1]) && q.mode_sy[1]) begin // see [R3] see [R20]
              d.rw = q.shreg[0]; // see [R4]
              d.st = grp_pkg::ST_ACK;
              d.sda_oe = 1'b1;
            end else begin
              d.st = grp_pkg::ST_IDLE;
            end
          end else begin
            if (q.bytecnt == 5'h01) begin
              // upper control bits are dropped here, see [R11]
              d.ctrl.lag = q.shreg[`GRP_CTRL_LAG_BIT];
              d.ctrl.wbank = q.shreg[`GRP_CTRL_WBANK_BIT];
              d.ctrl.rbank = q.shreg[`GRP_CTRL_RBANK_BIT];
              d.ctrl.src = q.shreg[`GRP_CTRL_SRC_BIT];
              d.ctrl_seen = 1'b1;
            end else if (widx < 5'(`GRP_NUM_CH)) begin
              // codes land in the bank chosen for writes, see [R6] see [R18]
              d.bank[q.ctrl.wbank].code[widx[3:0]] = q.shreg;
            end
            // every byte of a write is acknowledged, extra ones are dropped
            d.st = grp_pkg::ST_ACK;
            d.sda_oe = 1'b1;
          end
        end
      end
      // holding the acknowledge for one clock pulse
      grp_pkg::ST_ACK: begin
        if (scl_fall) begin
          if (q.rw) begin
            // read frames start with channel one right after the address, see [R19]
            txb = pick_code(q.bank[q.ctrl.rbank], q.bytecnt - `GRP_FIRST_CODE_RD); // see [R7]
            d.shreg = txb;
            d.sda_oe = ~txb[7]; // see [R5] see [R12]
            d.bitcnt = 3'h0;
            d.st = grp_pkg::ST_TX;
          end else begin
            d.sda_oe = 1'b0;
            d.st = grp_pkg::ST_RX;
          end
        end
      end
      // shifting a code out, each bit changed while the clock is low
      grp_pkg::ST_TX: begin
        if (scl_fall) begin
          if (q.bitcnt == 3'h7) begin
            d.sda_oe = 1'b0;
            d.last_bit = 1'b0;
            d.st = grp_pkg::ST_RACK;
          end else begin
            d.shreg = {q.shreg[6:0], 1'b0};
            d.sda_oe = ~q.shreg[6];
            d.bitcnt = q.bitcnt + 3'h1;
          end
        end
      end
      // controller answer: low carries on, high ends the read
      grp_pkg::ST_RACK: begin
        if (scl_rise) begin
          d.last_bit = sda_s;
        end else if (scl_fall) begin
          if (q.last_bit) begin
            d.st = grp_pkg::ST_IDLE; // see [R19]
          end else begin
            txb = pick_code(q.bank[q.ctrl.rbank], q.bytecnt); // see [R7]
            d.shreg = txb;
            d.sda_oe = ~txb[7];
            d.bitcnt = 3'h0;
            d.bytecnt = (q.bytecnt == 5'h1f) ? q.bytecnt : q.bytecnt + 5'h01;
            d.st = grp_pkg::ST_TX;
          end
        end
      end
    endcase

    // a start restarts the sequencer from any state, a stop frees the line
    if (start_ev) begin
      d.st = grp_pkg::ST_RX; // see [R1]
      d.bitcnt = 3'h0;
      d.bytecnt = 5'h00;
      d.last_bit = 1'b0;
      d.sda_oe = 1'b0;
    end else if (stop_ev) begin
      d.st = grp_pkg::ST_IDLE;
      d.sda_oe = 1'b0;
    end

    // internal refresh oscillator, free running, see [R14]
    if (q.osc_cnt == 12'(`GRP_OSC_HALF_CYC - 1)) begin
      d.osc_cnt = 12'h000;
      d.osc = ~q.osc;
    end else begin
      d.osc_cnt = q.osc_cnt + 12'h001;
    end
    // pin stays released until a control byte asks for the internal source
    d.osc_oe = q.ctrl_seen & ~q.ctrl.src; // see [R8] see [R9] see [R15]

    // switches follow the refresh clock level, optionally lagged
    if (q.rclk_sy[1] != q.sw_open) begin
      if (!q.ctrl.lag || q.lag_cnt == 9'(`GRP_LAG_CYC - 1)) begin // see [R10]
        d.sw_open = q.rclk_sy[1]; // see [R13]
        d.lag_cnt = 9'h000;
      end else begin
        d.lag_cnt = q.lag_cnt + 9'h001;
      end
    end else begin
      d.lag_cnt = 9'h000;
    end

    // hand the selected set to the refresh domain whenever it is idle;
    // shadow stays still until the toggle comes back, so no word tears
    if (q.req == q.ack_sy[1]) begin
      d.shadow = q.bank[q.bsel_sy[1]]; // see [R21] see [R16]
      d.req = ~q.req;
    end
  end

  // core state register, constants only under reset
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      q <= '0;
      q.ctrl <= `GRP_CTRL_RESET;
    end else begin
      q <= d;
    end
  end

  // refresh domain: takes a new set only when the request toggle moved
  always_comb begin
    rd = rq;
    rd.req_sy = {rq.req_sy[0], q.req};
    if (rq.req_sy[1] != rq.seen) begin
      rd.codes = q.shadow; // see [R13] see [R16]
      rd.seen = rq.req_sy[1];
    end
  end

  // outputs are refreshed on the falling refresh edge
  always_ff @(negedge REFRESH_CLOCK_PIN_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rq <= '0;
    end else begin
      rq <= rd;
    end
  end

  // every output straight from a flip-flop
  assign SDA_OUT = q.sda_lvl;
  assign SDA_OE_OUT = q.sda_oe;
  assign REFRESH_CLOCK_PIN_OUT = q.osc;
  assign REFRESH_CLOCK_PIN_OE_OUT = q.osc_oe;
  assign SWITCH_OPEN_OUT = q.sw_open;
  assign CHANNEL_CODES_OUT = rq.codes;

  // checks in the core domain, except a_refresh_load on the falling refresh edge
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RST_N_IN);

  // address byte to us in a standard frame is acknowledged
  a_addr_ack_own: assert property ( // see [R2]
    (q.st == grp_pkg::ST_RX && scl_fall && q.last_bit && q.bytecnt == 5'h00 &&
     !start_ev && !stop_ev && q.mode_sy[1] &&
     q.shreg[7:1] == {`GRP_ADDR_HIGH6, q.a0_sy[1]})
    |=> (q.st == grp_pkg::ST_ACK && q.sda_oe))
    else $error("own address not acknowledged");

  // any other address leaves the line released
  a_addr_foreign_nack: assert property ( // see [R1]
    (q.st == grp_pkg::ST_RX && scl_fall && q.last_bit && q.bytecnt == 5'h00 &&
     q.shreg[7:1] != {`GRP_ADDR_HIGH6, q.a0_sy[1]})
    |=> !q.sda_oe [*3])
    else $error("foreign address acknowledged");

  // direction latched from the address byte
  a_dir_latched: assert property ( // see [R4]
    (q.st == grp_pkg::ST_ACK && q.bytecnt == 5'h01 && $past(q.bytecnt) == 5'h00)
    |-> q.rw == $past(q.shreg[0]))
    else $error("direction bit not taken from address byte");

  // control byte keeps only its low four bits
  a_ctrl_low_bits: assert property ( // see [R11]
    (q.st == grp_pkg::ST_RX && scl_fall && q.last_bit && q.bytecnt == 5'h01 &&
     !start_ev && !stop_ev)
    |=> (q.ctrl == $past(q.shreg[3:0]) && q.ctrl_seen))
    else $error("control byte not stored");

  // slot that the byte now in the shift register is meant for
  logic [4:0] code_slot;
  assign code_slot = q.bytecnt - `GRP_FIRST_CODE_WR;

  // code byte lands in the write bank
  a_code_to_bank: assert property ( // see [R6]
    (q.st == grp_pkg::ST_RX && scl_fall && q.last_bit && !start_ev && !stop_ev &&
     q.bytecnt >= `GRP_FIRST_CODE_WR && q.bytecnt < 5'(`GRP_NUM_CH + 2))
    |=> q.bank[$past(q.ctrl.wbank)].code[$past(code_slot[3:0])] == $past(q.shreg))
    else $error("code byte not stored in write bank");

  // first read bit is the msb of channel one from the read bank
  a_read_first_msb: assert property ( // see [R5]
    (q.st == grp_pkg::ST_ACK && q.rw && scl_fall && !start_ev && !stop_ev &&
     q.bytecnt == 5'h01)
    |=> q.sda_oe == ~q.bank[q.ctrl.rbank].code[0][7])
    else $error("read does not start with channel one msb");

  // released line whenever idle
  a_idle_released: assert property ( // see [R19]
    (q.st == grp_pkg::ST_IDLE && $past(q.st) == grp_pkg::ST_IDLE) |-> !q.sda_oe)
    else $error("data line driven while idle");

  // pin enable follows the source choice
  a_pin_dir: assert property ( // see [R9]
    q.ctrl.src |=> !q.osc_oe)
    else $error("refresh pin driven in external mode");

  // oscillator toggles only at the half period
  a_osc_half: assert property ( // see [R14]
    $changed(q.osc) |-> $past(q.osc_cnt) == 12'(OSC_HALF - 1))
    else $error("oscillator half period wrong");

  // with lag on, a rising refresh level waits before opening switches
  a_lag_hold: assert property ( // see [R10]
    (q.ctrl.lag && q.rclk_sy[1] && !q.sw_open && q.lag_cnt == 9'h000)
    |=> !q.sw_open [*8])
    else $error("switches opened before lag");

  // without lag the switches follow at once
  a_no_lag_follow: assert property ( // see [R13]
    (!q.ctrl.lag && q.rclk_sy[1] != q.sw_open) |=> q.sw_open == $past(q.rclk_sy[1]))
    else $error("switches did not follow refresh clock");

  // refresh domain loads the shadow set when the toggle moves
  a_refresh_load: assert property ( // see [R13]
    @(negedge REFRESH_CLOCK_PIN_IN) disable iff (!RST_N_IN)
    (rq.req_sy[1] != rq.seen) |=> rq.seen == $past(rq.req_sy[1]))
    else $error("refresh domain missed a code set");

  // main scenarios
  c_write_frame: cover property (q.st == grp_pkg::ST_ACK && !q.rw &&
                                 q.bytecnt == 5'(`GRP_NUM_CH + 2));
  c_read_nack: cover property (q.st == grp_pkg::ST_RACK && scl_fall && q.last_bit);
  c_ext_source: cover property (q.ctrl_seen && q.ctrl.src);
  c_lagged_open: cover property (q.ctrl.lag && $rose(q.sw_open));

endmodule
`default_nettype wire

// File: inc/grp_params.svh
// Purpose: constants for the gamma reference programmer target logic
// Assumes: core clock of 100 MHz
// Notes: timing counts are derived from the printed times and the clock rate
`ifndef GRP_PARAMS_SVH
`define GRP_PARAMS_SVH

// fixed upper six bits of the target address
`define GRP_ADDR_HIGH6 6'h3a
// number of reference channels
`define GRP_NUM_CH 14
// byte index of the first code byte in a write and in a read frame
`define GRP_FIRST_CODE_WR 5'h02
`define GRP_FIRST_CODE_RD 5'h01
// code returned when the controller reads past the last channel
`define GRP_IDLE_CODE 8'hff

// control byte field positions
`define GRP_CTRL_LAG_BIT 0
`define GRP_CTRL_WBANK_BIT 1
`define GRP_CTRL_RBANK_BIT 2
`define GRP_CTRL_SRC_BIT 3
// control settings after reset: first bank both ways, internal oscillator, no lag
`define GRP_CTRL_RESET 4'h0

// clock and refresh timing
`define GRP_CLK_HZ 100000000
`define GRP_CLK_NS 10
`define GRP_OSC_HZ 21000
`define GRP_OSC_HALF_CYC (`GRP_CLK_HZ / (2 * `GRP_OSC_HZ))
`define GRP_LAG_NS 3500
`define GRP_LAG_CYC ((`GRP_LAG_NS + `GRP_CLK_NS - 1) / `GRP_CLK_NS)

`endif

// File: inc/grp_pkg.sv
// Purpose: types shared by the gamma reference programmer
// Assumes: grp_params.svh on the include path
// Notes: all state of each clock domain of the target is one packed struct declared here
`include "grp_params.svh"

package grp_pkg;

  // serial bus sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_RACK
  } grp_bus_state_e;

  // retained control settings, bit order as on the wire
  typedef struct packed {
    logic src;
    logic rbank;
    logic wbank;
    logic lag;
  } grp_ctrl_s;

  typedef logic [7:0] grp_code_t;

  // one full set of channel codes, channel one in element 0
  typedef struct packed {
    grp_code_t [`GRP_NUM_CH-1:0] code;
  } grp_code_set_s;

  // core clock domain state
  typedef struct packed {
    logic [1:0] scl_sy;
    logic [1:0] sda_sy;
    logic [1:0] a0_sy;
    logic [1:0] mode_sy;
    logic [1:0] bsel_sy;
    logic [1:0] rclk_sy;
    logic scl_p;
    logic sda_p;
    grp_bus_state_e st;
    logic [2:0] bitcnt;
    logic [7:0] shreg;
    logic [4:0] bytecnt;
    logic rw;
    logic last_bit;
    logic sda_oe;
    logic sda_lvl;
    grp_ctrl_s ctrl;
    logic ctrl_seen;
    grp_code_set_s [1:0] bank;
    grp_code_set_s shadow;
    logic req;
    logic [1:0] ack_sy;
    logic [11:0] osc_cnt;
    logic osc;
    logic osc_oe;
    logic [8:0] lag_cnt;
    logic sw_open;
  } grp_core_s;

  // refresh clock domain state
  typedef struct packed {
    logic [1:0] req_sy;
    logic seen;
    grp_code_set_s codes;
  } grp_refresh_s;

endpackage

// File: verification/grp_bus_ctrl_model.sv
// Purpose: behavioural two-wire bus controller facing the target
// Assumes: the bench resolves the data line with a pull-up
// Notes: drives only at falling core clock edges; half sets the clock phase length
`timescale 1ns/1ps
`default_nettype none

module grp_bus_ctrl_model (
  // time base
  input wire logic CLK_IN,
  // resolved data line level
  input wire logic SDA_IN,
  // controller drives
  output var logic SCL_OUT,
  output var logic SDA_LOW_OUT
);
  // clock phase in core cycles; raise it to act as a slow controller
  int half = 10;

  // bus idle: both lines high
  initial begin
    SCL_OUT = 1'h1;
    SDA_LOW_OUT = 1'h0;
  end

  // wait n core cycles, landing on a falling edge
  task automatic hold(input int n);
    repeat (n) @(negedge CLK_IN);
  endtask

  // start or repeated start: data falls while the clock is high
  task automatic start();
    SDA_LOW_OUT = 1'h0;
    hold(half / 2);
    SCL_OUT = 1'h1;
    hold(half);
    SDA_LOW_OUT = 1'h1;
    hold(half);
    SCL_OUT = 1'h0;
    hold(half / 2);
  endtask

  // stop: data rises while the clock is high
  task automatic stop();
    SDA_LOW_OUT = 1'h1;
    hold(half / 2);
    SCL_OUT = 1'h1;
    hold(half);
    SDA_LOW_OUT = 1'h0;
    hold(half);
  endtask

  // one clock pulse; data only changes while the clock is low
  task automatic one_bit(input logic b, output logic s);
    SDA_LOW_OUT = ~b;
    hold(half / 2);
    SCL_OUT = 1'h1;
    hold(half);
    s = SDA_IN;
    SCL_OUT = 1'h0;
    hold(half / 2);
  endtask

  // eight bits msb first, then the acknowledge slot
  task automatic xfer(input logic [7:0] tx, input logic ack_tx,
                      output logic [7:0] rx, output logic ack_rx);
    for (int i = 7; i >= 0; i--) begin
      one_bit(tx[i], rx[i]);
    end
    one_bit(ack_tx, ack_rx);
  endtask

  // write frame; all_ack is high when every byte was acknowledged
  task automatic write_frame(input logic [7:0] addr, input logic [7:0] ctrl, input int n,
                             input grp_pkg::grp_code_set_s set, output logic all_ack);
    logic [7:0] rx;
    logic ak;
    start();
    xfer(addr, 1'h1, rx, ak); // direction bit low in addr
    all_ack = ~ak;
    // control byte, then codes from channel one on
    xfer(ctrl, 1'h1, rx, ak);
    all_ack = all_ack & ~ak;
    for (int i = 0; i < n; i++) begin
      xfer(set.code[i], 1'h1, rx, ak);
      all_ack = all_ack & ~ak;
    end
    stop();
  endtask

  // read frame of n bytes; a byte past channel fourteen lands in extra
  task automatic read_frame(input logic [7:0] addr, input int n,
                            output grp_pkg::grp_code_set_s set, output logic [7:0] extra);
    logic [7:0] rx;
    logic ak;
    set = '0;
    extra = 8'h00;
    start();
    xfer(addr, 1'h1, rx, ak); // direction bit high in addr
    for (int i = 0; i < n; i++) begin
      // every byte acked but the last, which is refused so the device lets go
      xfer(8'hff, 1'(i == n - 1), rx, ak);
      if (i < 14) begin
        set.code[i] = rx;
      end else begin
        extra = rx;
      end
    end
    stop();
  endtask
endmodule
`default_nettype wire

// File: verification/grp_target_tb_top.sv
// Purpose: self-checking bench for the reference programmer target
// Assumes: controller model drives the serial bus at falling clock edges
// Notes: external refresh clock is gated so refresh can be stopped on purpose
`timescale 1ns/1ps
`default_nettype none

module grp_target_tb_top;
  // address-filter rows: straps, address byte, expected ack level
  typedef struct {logic a0; logic mode; logic [7:0] addr; logic nack;} grp_row_s;
  grp_row_s rows [7] = '{'{1'h1, 1'h1, 8'hea, 1'h0}, '{1'h1, 1'h1, 8'he8, 1'h1},
    '{1'h0, 1'h1, 8'he8, 1'h0}, '{1'h0, 1'h1, 8'hea, 1'h1}, '{1'h0, 1'h1, 8'h68, 1'h1},
    '{1'h0, 1'h1, 8'hf8, 1'h1}, '{1'h0, 1'h0, 8'he8, 1'h1}};
  logic clk, rst_n, a0, mode, bsel, ext_clk, ext_run, ok, ak;
  logic sda_oe, sda_o, rclk_o, rclk_oe, sw_open;
  logic [7:0] rx, extra, wr_addr, rd_addr;
  wire logic scl, sda_low, sda_wire, rclk_wire;
  grp_pkg::grp_code_set_s codes, exp_a, exp_b, got;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int n;

  // open-drain data line with pull-up; refresh pin driven by device or system
  assign sda_wire = ~(sda_low | (sda_oe & ~sda_o));
  assign rclk_wire = rclk_oe ? rclk_o : (ext_clk & ext_run);

  grp_target u_grp_target (.CLK_IN(clk), .RST_N_IN(rst_n), .SCL_IN(scl), .SDA_IN(sda_wire),
    .SDA_OUT(sda_o), .SDA_OE_OUT(sda_oe), .ADDRESS_SELECT_PIN_IN(a0),
    .FRAME_MODE_PIN_IN(mode), .BANK_SELECT_PIN_IN(bsel), .REFRESH_CLOCK_PIN_IN(rclk_wire),
    .REFRESH_CLOCK_PIN_OUT(rclk_o), .REFRESH_CLOCK_PIN_OE_OUT(rclk_oe),
    .CHANNEL_CODES_OUT(codes), .SWITCH_OPEN_OUT(sw_open));

  grp_bus_ctrl_model u_grp_bus_ctrl_model (.CLK_IN(clk), .SDA_IN(sda_wire),
    .SCL_OUT(scl), .SDA_LOW_OUT(sda_low));

  // core clock, 10 ns
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // system refresh clock, 32 ns, phase unrelated; no load changes at its rises
  initial begin
    ext_clk = 1'h0;
    #3;
    forever #16 ext_clk = ~ext_clk;
  end

  // hang guard, well above the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      errors++;
      $display("wrong value at %0t: run did not finish", $time);
      conclude();
    end
  end

  // wide enough for the code set plus three status bits
  task automatic chk(input logic [127:0] got_v, input logic [127:0] exp_v, input string what);
    num_checks++;
    if (got_v !== exp_v) begin
      errors++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask

  // cycles until the device oscillator output changes, bounded
  task automatic edge_wait(output int k);
    logic last;
    last = rclk_o;
    k = 0;
    while (rclk_o === last && k < 6000) begin
      @(negedge clk);
      k++;
    end
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // own addresses follow the select strap
  task automatic set_a0(input logic v);
    a0 = v;
    wr_addr = {6'h3a, v, 1'h0};
    rd_addr = {6'h3a, v, 1'h1};
    u_grp_bus_ctrl_model.hold(4);
  endtask

  // main sequence
  initial begin
    rst_n = 1'h0;
    a0 = 1'h1;
    mode = 1'h1;
    bsel = 1'h0;
    ext_run = 1'h1;
    for (int i = 0; i < 14; i++) begin
      exp_a.code[i] = 8'hba ^ 8'(i);
      exp_b.code[i] = 8'h45 + 8'(i * 17);
    end
    repeat (5) @(negedge clk);
    chk({sda_oe, rclk_oe, sw_open, codes}, '0, "outputs in reset");
    rst_n = 1'h1;
    set_a0(1'h1);
    chk(rclk_oe, 1'h0, "refresh pin released");
    // address filter table
    foreach (rows[r]) begin
      a0 = rows[r].a0;
      mode = rows[r].mode;
      u_grp_bus_ctrl_model.hold(4);
      u_grp_bus_ctrl_model.start();
      u_grp_bus_ctrl_model.xfer(rows[r].addr, 1'h1, rx, ak);
      u_grp_bus_ctrl_model.stop();
      chk(ak, rows[r].nack, "address ack");
    end
    mode = 1'h1;
    set_a0(1'h1);
    // first bank, external source, upper control bits set
    u_grp_bus_ctrl_model.write_frame(wr_addr, 8'hf8, 14, exp_a, ok);
    chk(ok, 1'h1, "write frame acks");
    chk(rclk_oe, 1'h0, "pin input in external mode");
    u_grp_bus_ctrl_model.read_frame(rd_addr, 14, got, extra);
    chk(got, exp_a, "read back first bank");
    // second bank both ways, slow controller, other strap address
    set_a0(1'h0);
    u_grp_bus_ctrl_model.half = 40;
    u_grp_bus_ctrl_model.write_frame(wr_addr, 8'h0e, 14, exp_b, ok);
    u_grp_bus_ctrl_model.half = 10;
    chk(ok, 1'h1, "slow write acks");
    u_grp_bus_ctrl_model.read_frame(rd_addr, 14, got, extra);
    chk(got, exp_b, "read back second bank");
    set_a0(1'h1);
    // control only: read from first bank, codes kept; read one byte past the end
    u_grp_bus_ctrl_model.write_frame(wr_addr, 8'h0a, 0, exp_b, ok);
    u_grp_bus_ctrl_model.read_frame(rd_addr, 15, got, extra);
    chk(got, exp_a, "banks retained");
    chk(extra, 8'hff, "byte past channel fourteen");
    // refresh from the system clock
    u_grp_bus_ctrl_model.hold(300);
    chk(codes, exp_a, "refreshed first bank");
    ext_run = 1'h0;
    bsel = 1'h1;
    u_grp_bus_ctrl_model.hold(300);
    chk(codes, exp_a, "codes held without refresh edges");
    ext_run = 1'h1;
    u_grp_bus_ctrl_model.hold(300);
    chk(codes, exp_b, "refreshed second bank");
    // internal oscillator drives the pin
    u_grp_bus_ctrl_model.write_frame(wr_addr, 8'h00, 0, exp_b, ok);
    u_grp_bus_ctrl_model.hold(2);
    chk(rclk_oe, 1'h1, "pin driven in internal mode");
    edge_wait(n);
    edge_wait(n);
    chk(n, 2380, "oscillator half period");
    if (rclk_o !== 1'h1) edge_wait(n);
    u_grp_bus_ctrl_model.hold(8);
    chk(sw_open, 1'h1, "switch opens on rise");
    // lagged switch timing
    u_grp_bus_ctrl_model.write_frame(wr_addr, 8'h01, 0, exp_b, ok);
    edge_wait(n);
    if (rclk_o !== 1'h1) edge_wait(n);
    u_grp_bus_ctrl_model.hold(300);
    chk(sw_open, 1'h0, "switch still closed in lag");
    u_grp_bus_ctrl_model.hold(60);
    chk(sw_open, 1'h1, "switch open after lag");
    // back to the system clock: a driven pin must be let go again
    u_grp_bus_ctrl_model.write_frame(wr_addr, 8'h08, 0, exp_b, ok);
    u_grp_bus_ctrl_model.hold(2);
    chk(rclk_oe, 1'h0, "pin released in external mode");
    // reset in mid-run clears outputs, settings and both banks
    rst_n = 1'h0;
    u_grp_bus_ctrl_model.hold(5);
    chk({sda_oe, rclk_oe, sw_open, codes}, '0, "outputs in second reset");
    rst_n = 1'h1;
    u_grp_bus_ctrl_model.hold(4);
    u_grp_bus_ctrl_model.read_frame(rd_addr, 14, got, extra);
    chk(got, '0, "banks cleared by reset");
    conclude();
  end
endmodule
`default_nettype wire
